// ==== core/raic_defines.svh ====
`ifndef RAIC_DEFINES_SVH
`define RAIC_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define RAIC_IDX_STATUS      8'h01
`define RAIC_IDX_EQ_CTRL     8'h1e
`define RAIC_IDX_ADAPT       8'h31
`define RAIC_IDX_EYE_IRQ     8'h32
`define RAIC_IDX_EYE_GATE    8'h33
`define RAIC_IDX_ALT_MERIT   8'h6e
`define RAIC_IDX_IRQ_STAT    8'h40
`define RAIC_IDX_IRQ_MASK    8'h41

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RAIC_RST_ADAPT       8'h20
`define RAIC_RST_EYE_IRQ     8'h11
`define RAIC_RST_EYE_GATE    8'h88
`define RAIC_RST_EQ_CTRL     8'h08
`define RAIC_RST_ALT_MERIT   8'h00
`define RAIC_RST_IRQ_MASK    4'h0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RAIC_ADAPT_WMASK     8'hfb
`define RAIC_ALT_WMASK       8'h80
`define RAIC_EQ_CTRL_WMASK   8'h0a
`define RAIC_BIT_PATERR_EN   7
`define RAIC_MODE_HI         6
`define RAIC_MODE_LO         5
`define RAIC_MERIT_HI        4
`define RAIC_MERIT_LO        3
`define RAIC_BIT_LOCK_EN     1
`define RAIC_BIT_CARR_EN     0
`define RAIC_BIT_DFE_OFF     3
`define RAIC_BIT_DFE_ON      1
`define RAIC_BIT_ALT_MERIT   7
`define RAIC_ST_LOCK         5
`define RAIC_ST_CARR         0
`define RAIC_IRQ_PAT         0
`define RAIC_IRQ_LOCK        1
`define RAIC_IRQ_CARR        2
`define RAIC_IRQ_EYE         3
`define RAIC_EYE_UNIT_SHIFT  3

// ----------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------
`define RAIC_RESP_OKAY       2'h0
`define RAIC_RESP_SLVERR     2'h2

`endif

// ==== core/raic_pkg.sv ====
`default_nettype none
package raic_pkg;

	// Adaptation sequence states
	typedef enum logic [4:0]
	{
		SEQ_IDLE  = 5'h01,
		SEQ_CTLE1 = 5'h02,
		SEQ_DFE   = 5'h04,
		SEQ_CTLE2 = 5'h08,
		SEQ_DONE  = 5'h10
	} raic_seq_state_t;

	// Sequencer state
	typedef struct packed
	{
		raic_seq_state_t state;
		logic            ctle_run;
		logic            dfe_run;
		logic            done;
	} raic_seq_regs_t;

	// Register bank and bus slave state
	typedef struct packed
	{
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        aw_full;
		logic        w_full;
		logic [7:0]  waddr_idx;
		logic        waddr_ok;
		logic [7:0]  wdata;
		logic        wstrb0;
		logic        arready;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		logic [7:0]  adapt;
		logic [7:0]  eye_irq;
		logic [7:0]  eye_gate;
		logic [7:0]  eq_ctrl;
		logic [7:0]  alt_merit;
		logic [3:0]  irq_stat;
		logic [3:0]  irq_mask;
		logic        irq;
		logic        restart;
		logic        lock_s1;
		logic        lock_s2;
		logic        lock_d;
		logic        carr_s1;
		logic        carr_s2;
		logic        carr_d;
		logic        merit_h;
		logic        merit_v;
		logic        merit_alt;
	} raic_regs_t;

endpackage
`default_nettype wire

// ==== core/raic_seq_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface raic_seq_if #(parameter int EYE_W = 8);

	logic [1:0]       mode;
	logic             dfe_ok;
	logic             restart;
	logic             ctle_optimal;
	logic             dfe_done;
	logic             cdr_locked;
	logic [3:0]       h_gate;
	logic [3:0]       v_gate;
	logic [EYE_W-1:0] h_eye;
	logic [EYE_W-1:0] v_eye;
	logic             ctle_run;
	logic             dfe_run;
	logic             done;

	// Register bank side
	modport ctl
	(
		output mode, dfe_ok, restart, ctle_optimal, dfe_done, cdr_locked,
		output h_gate, v_gate, h_eye, v_eye,
		input  ctle_run, dfe_run, done
	);

	// Sequencer side
	modport seq
	(
		input  mode, dfe_ok, restart, ctle_optimal, dfe_done, cdr_locked,
		input  h_gate, v_gate, h_eye, v_eye,
		output ctle_run, dfe_run, done
	);

endinterface
`default_nettype wire

// ==== core/raic_adapt_seq.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "raic_defines.svh"
module raic_adapt_seq #(parameter int EYE_W = 8)
(
	input  wire logic core_clk,
	input  wire logic rst,
	raic_seq_if.seq   sb
);

	raic_pkg::raic_seq_regs_t st_reg;
	raic_pkg::raic_seq_regs_t st_next;
	logic                     eye_ok;
	logic [EYE_W-1:0]         h_min;
	logic [EYE_W-1:0]         v_min;

	// ----------------------------------------------------------------
	// Eye gate before DFE
	// ----------------------------------------------------------------
	assign h_min  = {{(EYE_W-7){1'b0}}, sb.h_gate, 3'h0};
	assign v_min  = {{(EYE_W-7){1'b0}}, sb.v_gate, 3'h0};
	assign eye_ok = (sb.h_eye >= h_min) && (sb.v_eye >= v_min); // see RL11

	// ----------------------------------------------------------------
	// Sequence control
	// ----------------------------------------------------------------
	always_comb
	begin
		st_next = st_reg;
		unique case (st_reg.state)
			raic_pkg::SEQ_IDLE:
			begin
				if (sb.mode == 2'h1)
					st_next.state = raic_pkg::SEQ_CTLE1; // see RL2
				else if (sb.mode != 2'h0 && sb.dfe_ok)
					st_next.state = raic_pkg::SEQ_CTLE1; // see RL5
			end
			raic_pkg::SEQ_CTLE1:
			begin
				if (sb.mode == 2'h1 && sb.ctle_optimal)
					st_next.state = raic_pkg::SEQ_DONE; // see RL2
				else if (sb.mode == 2'h2 && sb.ctle_optimal)
					st_next.state = raic_pkg::SEQ_DFE; // see RL3
				else if (sb.mode == 2'h3 && sb.cdr_locked && eye_ok)
					st_next.state = raic_pkg::SEQ_DFE; // see RL4
			end
			raic_pkg::SEQ_DFE:
			begin
				if (sb.dfe_done)
					st_next.state = raic_pkg::SEQ_CTLE2; // see RL3
			end
			raic_pkg::SEQ_CTLE2:
			begin
				if (sb.ctle_optimal)
					st_next.state = raic_pkg::SEQ_DONE; // see RL4
			end
			raic_pkg::SEQ_DONE:
			begin
				st_next.state = raic_pkg::SEQ_DONE;
			end
			default:
			begin
				st_next.state = raic_pkg::SEQ_IDLE;
			end
		endcase
		// Mode 00 or a new mode restarts from idle
		if (sb.mode == 2'h0 || sb.restart)
			st_next.state = raic_pkg::SEQ_IDLE; // see RL2
		st_next.ctle_run = (st_next.state == raic_pkg::SEQ_CTLE1) || (st_next.state == raic_pkg::SEQ_CTLE2);
		st_next.dfe_run  = (st_next.state == raic_pkg::SEQ_DFE);
		st_next.done     = (st_next.state == raic_pkg::SEQ_DONE);
	end

	// State register
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			st_reg.state    <= raic_pkg::SEQ_IDLE;
			st_reg.ctle_run <= 1'b0;
			st_reg.dfe_run  <= 1'b0;
			st_reg.done     <= 1'b0;
		end
		else
			st_reg <= st_next;
	end

	// Outputs from flops
	assign sb.ctle_run = st_reg.ctle_run;
	assign sb.dfe_run  = st_reg.dfe_run;
	assign sb.done     = st_reg.done;

endmodule
`default_nettype wire

// ==== core/raic_top.sv ====
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "raic_defines.svh"
// Overview of operation
// RL1: With the pattern error enable set, each pattern error pulse sets the pattern error interrupt flag.
// RL2: Adaptation select 00 stops all adaptation and 01 runs only the CTLE until optimal.
// RL3: Select 10 runs the CTLE until optimal, then the DFE, then the CTLE again.
// RL4: Select 11 runs the CTLE until lock, then the DFE, then the equalizer until optimal.
// RL5: Software enables the DFE in the equalizer control register before selecting 10 or 11.
// RL6: Merit select 00 and 11 use both eye openings, 01 horizontal only, 10 vertical only.
// RL7: The alternate merit bit, when set, selects the alternate figure and overrides the merit select.
// RL8: The lock drop enable gates the lock loss interrupt, whose flag shows in status bit 5.
// RL9: The carrier drop enable gates the signal loss interrupt, whose flag shows in status bit 0.
// RL10: Two four-bit eye interrupt levels each count in units of eight eye counts.
// RL11: In select 11 the DFE starts only once both eye openings reach their gate levels.
// RL12: The eye interrupt flags when either eye opening falls below its level times eight.
module raic_top #(
	parameter int AW    = 12,
	parameter int EYE_W = 8
)
(
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic [AW-1:0]    s_axi_awaddr,
	input  wire logic             s_axi_awvalid,
	output var  logic             s_axi_awready,
	input  wire logic [31:0]      s_axi_wdata,
	input  wire logic [3:0]       s_axi_wstrb,
	input  wire logic             s_axi_wvalid,
	output var  logic             s_axi_wready,
	output var  logic [1:0]       s_axi_bresp,
	output var  logic             s_axi_bvalid,
	input  wire logic             s_axi_bready,
	input  wire logic [AW-1:0]    s_axi_araddr,
	input  wire logic             s_axi_arvalid,
	output var  logic             s_axi_arready,
	output var  logic [31:0]      s_axi_rdata,
	output var  logic [1:0]       s_axi_rresp,
	output var  logic             s_axi_rvalid,
	input  wire logic             s_axi_rready,
	input  wire logic             pattern_error,
	input  wire logic             cdr_lock_async,
	input  wire logic             signal_detect_async,
	input  wire logic             eye_valid,
	input  wire logic [EYE_W-1:0] horizontal_eye_opening,
	input  wire logic [EYE_W-1:0] vertical_eye_opening,
	input  wire logic             ctle_optimal,
	input  wire logic             dfe_done,
	output var  logic             ctle_adapt_run,
	output var  logic             dfe_adapt_run,
	output var  logic             adapt_done,
	output var  logic             merit_use_horiz,
	output var  logic             merit_use_vert,
	output var  logic             merit_use_alt,
	output var  logic             irq
);

	raic_pkg::raic_regs_t st_reg;
	raic_pkg::raic_regs_t st_next;
	raic_seq_if #(.EYE_W(EYE_W)) seq_bus();

	logic [EYE_W-1:0] h_lvl;
	logic [EYE_W-1:0] v_lvl;
	logic [3:0]       ev_set;
	logic [3:0]       ev_clr;
	logic             aw_take;
	logic             w_take;
	logic             ar_take;
	logic [7:0]       rd_idx;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------

	// True when the byte address hits a mapped word
	function automatic logic raic_map_ok(input logic [AW-1:0] addr);
		logic [7:0] idx;
		logic       hit;
		idx = addr[9:2];
		hit = 1'b0;

		// Unaligned or out-of-range addresses miss
		if (addr[1:0] == 2'h0 && (AW <= 10 || (addr >> 10) == '0))
		begin
			unique case (idx)
				`RAIC_IDX_STATUS, `RAIC_IDX_EQ_CTRL, `RAIC_IDX_ADAPT, `RAIC_IDX_EYE_IRQ,
				`RAIC_IDX_EYE_GATE, `RAIC_IDX_ALT_MERIT, `RAIC_IDX_IRQ_STAT, `RAIC_IDX_IRQ_MASK:
					hit = 1'b1;
				default:
					hit = 1'b0;
			endcase
		end
		return hit;
	endfunction

	// ----------------------------------------------------------------
	// Event detection
	// ----------------------------------------------------------------

	// Eye interrupt levels in eye counts
	assign h_lvl = {{(EYE_W-7){1'b0}}, st_reg.eye_irq[7:4], 3'h0}; // see RL10
	assign v_lvl = {{(EYE_W-7){1'b0}}, st_reg.eye_irq[3:0], 3'h0}; // see RL10

	// Events that set sticky flags, all but the eye event gated by an enable
	always_comb
	begin
		ev_set = 4'h0;
		ev_set[`RAIC_IRQ_PAT]  = pattern_error && st_reg.adapt[`RAIC_BIT_PATERR_EN]; // see RL1
		ev_set[`RAIC_IRQ_LOCK] = st_reg.lock_d && !st_reg.lock_s2 && st_reg.adapt[`RAIC_BIT_LOCK_EN]; // see RL8
		ev_set[`RAIC_IRQ_CARR] = st_reg.carr_d && !st_reg.carr_s2 && st_reg.adapt[`RAIC_BIT_CARR_EN]; // see RL9
		ev_set[`RAIC_IRQ_EYE]  = eye_valid && ((horizontal_eye_opening < h_lvl) ||
			(vertical_eye_opening < v_lvl)); // see RL12
	end

	// Channel handshakes
	assign aw_take = s_axi_awvalid && st_reg.awready;
	assign w_take  = s_axi_wvalid && st_reg.wready;
	assign ar_take = s_axi_arvalid && st_reg.arready;
	assign rd_idx  = s_axi_araddr[9:2];

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		st_next         = st_reg;
		ev_clr          = 4'h0;
		st_next.restart = 1'b0;

		// Level inputs through two flops
		// A third flop keeps the last synced level for edge detection
		st_next.lock_s1 = cdr_lock_async;
		st_next.lock_s2 = st_reg.lock_s1;
		st_next.lock_d  = st_reg.lock_s2;
		st_next.carr_s1 = signal_detect_async;
		st_next.carr_s2 = st_reg.carr_s1;
		st_next.carr_d  = st_reg.carr_s2;

		// Write address and data, taken in either order
		if (aw_take)
		begin
			st_next.awready   = 1'b0;
			st_next.aw_full   = 1'b1;
			st_next.waddr_idx = s_axi_awaddr[9:2];
			st_next.waddr_ok  = raic_map_ok(s_axi_awaddr);
		end
		if (w_take)
		begin
			st_next.wready = 1'b0;
			st_next.w_full = 1'b1;
			st_next.wdata  = s_axi_wdata[7:0];
			st_next.wstrb0 = s_axi_wstrb[0];
		end

		// Register write once both halves are held
		if (st_reg.aw_full && st_reg.w_full && !st_reg.bvalid)
		begin
			st_next.aw_full = 1'b0;
			st_next.w_full  = 1'b0;
			st_next.bvalid  = 1'b1;
			st_next.bresp   = st_reg.waddr_ok ? `RAIC_RESP_OKAY : `RAIC_RESP_SLVERR;
			// Unmapped writes answer an error and change nothing
			if (st_reg.waddr_ok && st_reg.wstrb0)
			begin
				unique case (st_reg.waddr_idx)
					`RAIC_IDX_ADAPT:
					begin
						st_next.adapt = st_reg.wdata & `RAIC_ADAPT_WMASK;
						// A new mode restarts the sequence
						if (st_reg.wdata[`RAIC_MODE_HI:`RAIC_MODE_LO] != st_reg.adapt[`RAIC_MODE_HI:`RAIC_MODE_LO])
							st_next.restart = 1'b1;
					end
					`RAIC_IDX_EYE_IRQ:
						st_next.eye_irq = st_reg.wdata;
					`RAIC_IDX_EYE_GATE:
						st_next.eye_gate = st_reg.wdata;
					`RAIC_IDX_EQ_CTRL:
						st_next.eq_ctrl = st_reg.wdata & `RAIC_EQ_CTRL_WMASK;
					`RAIC_IDX_ALT_MERIT:
						st_next.alt_merit = st_reg.wdata & `RAIC_ALT_WMASK;
					`RAIC_IDX_IRQ_STAT:
						ev_clr = st_reg.wdata[3:0];
					`RAIC_IDX_IRQ_MASK:
						st_next.irq_mask = st_reg.wdata[3:0];
					default:
						ev_clr = 4'h0;
				endcase
			end
		end

		// Write response taken
		if (st_reg.bvalid && s_axi_bready)
		begin
			st_next.bvalid  = 1'b0;
			st_next.awready = 1'b1;
			st_next.wready  = 1'b1;
		end

		// Read request
		if (ar_take)
		begin
			st_next.arready = 1'b0;
			st_next.rvalid  = 1'b1;
			st_next.rdata   = 32'h0;
			st_next.rresp   = raic_map_ok(s_axi_araddr) ? `RAIC_RESP_OKAY : `RAIC_RESP_SLVERR;
			// Unmapped reads return zero
			if (raic_map_ok(s_axi_araddr))
			begin
				unique case (rd_idx)
					`RAIC_IDX_STATUS:
					begin
						st_next.rdata[`RAIC_ST_LOCK] = st_reg.irq_stat[`RAIC_IRQ_LOCK]; // see RL8
						st_next.rdata[`RAIC_ST_CARR] = st_reg.irq_stat[`RAIC_IRQ_CARR]; // see RL9
					end
					`RAIC_IDX_ADAPT:
						st_next.rdata[7:0] = st_reg.adapt;
					`RAIC_IDX_EYE_IRQ:
						st_next.rdata[7:0] = st_reg.eye_irq;
					`RAIC_IDX_EYE_GATE:
						st_next.rdata[7:0] = st_reg.eye_gate;
					`RAIC_IDX_EQ_CTRL:
						st_next.rdata[7:0] = st_reg.eq_ctrl;
					`RAIC_IDX_ALT_MERIT:
						st_next.rdata[7:0] = st_reg.alt_merit;
					`RAIC_IDX_IRQ_STAT:
						st_next.rdata[3:0] = st_reg.irq_stat;
					`RAIC_IDX_IRQ_MASK:
						st_next.rdata[3:0] = st_reg.irq_mask;
					default:
						st_next.rdata = 32'h0;
				endcase
			end
		end
		if (st_reg.rvalid && s_axi_rready)
		begin
			st_next.rvalid  = 1'b0;
			st_next.arready = 1'b1;
		end

		// Sticky flags, a new event wins over the clear
		st_next.irq_stat = (st_reg.irq_stat & ~ev_clr) | ev_set; // see RL1
		st_next.irq      = |(st_next.irq_stat & st_next.irq_mask);

		// Figure of merit selection
		st_next.merit_alt = st_next.alt_merit[`RAIC_BIT_ALT_MERIT]; // see RL7
		if (st_next.merit_alt)
		begin
			st_next.merit_h = 1'b0; // see RL7
			st_next.merit_v = 1'b0;
		end
		else
		begin
			unique case (st_next.adapt[`RAIC_MERIT_HI:`RAIC_MERIT_LO])
				2'h1:
				begin
					st_next.merit_h = 1'b1; // see RL6
					st_next.merit_v = 1'b0;
				end
				2'h2:
				begin
					st_next.merit_h = 1'b0; // see RL6
					st_next.merit_v = 1'b1;
				end
				default:
				begin
					st_next.merit_h = 1'b1; // see RL6
					st_next.merit_v = 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			st_reg           <= '0;
			// Readies idle high so a request is taken at once
			st_reg.awready   <= 1'b1;
			st_reg.wready    <= 1'b1;
			st_reg.arready   <= 1'b1;
			st_reg.adapt     <= `RAIC_RST_ADAPT;
			st_reg.eye_irq   <= `RAIC_RST_EYE_IRQ;
			st_reg.eye_gate  <= `RAIC_RST_EYE_GATE;
			st_reg.eq_ctrl   <= `RAIC_RST_EQ_CTRL;
			st_reg.alt_merit <= `RAIC_RST_ALT_MERIT;
			st_reg.irq_mask  <= `RAIC_RST_IRQ_MASK;
			st_reg.merit_h   <= 1'b1;
			st_reg.merit_v   <= 1'b1;
		end
		else
			st_reg <= st_next;
	end

	// ----------------------------------------------------------------
	// Adaptation sequencer
	// ----------------------------------------------------------------

	// Bank to sequencer
	assign seq_bus.mode         = st_reg.adapt[`RAIC_MODE_HI:`RAIC_MODE_LO]; // see RL2
	assign seq_bus.dfe_ok       = !st_reg.eq_ctrl[`RAIC_BIT_DFE_OFF] && st_reg.eq_ctrl[`RAIC_BIT_DFE_ON]; // see RL5
	assign seq_bus.restart      = st_reg.restart;
	assign seq_bus.ctle_optimal = ctle_optimal;
	assign seq_bus.dfe_done     = dfe_done;
	// Lock reaches the sequencer only after the synchroniser
	assign seq_bus.cdr_locked   = st_reg.lock_s2;
	assign seq_bus.h_gate       = st_reg.eye_gate[7:4]; // see RL11
	assign seq_bus.v_gate       = st_reg.eye_gate[3:0]; // see RL11
	assign seq_bus.h_eye        = horizontal_eye_opening;
	assign seq_bus.v_eye        = vertical_eye_opening;

	raic_adapt_seq #(.EYE_W(EYE_W)) u_seq
	(
		.core_clk (core_clk),
		.rst      (rst),
		.sb       (seq_bus)
	);

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Bus channel outputs
	assign s_axi_awready   = st_reg.awready;
	assign s_axi_wready    = st_reg.wready;
	assign s_axi_bvalid    = st_reg.bvalid;
	assign s_axi_bresp     = st_reg.bresp;
	assign s_axi_arready   = st_reg.arready;
	assign s_axi_rvalid    = st_reg.rvalid;
	assign s_axi_rresp     = st_reg.rresp;
	assign s_axi_rdata     = st_reg.rdata;

	// Sequencer, merit and interrupt outputs
	assign ctle_adapt_run  = seq_bus.ctle_run;
	assign dfe_adapt_run   = seq_bus.dfe_run;
	assign adapt_done      = seq_bus.done;
	assign merit_use_horiz = st_reg.merit_h;
	assign merit_use_vert  = st_reg.merit_v;
	assign merit_use_alt   = st_reg.merit_alt;
	assign irq             = st_reg.irq; // see RL1

endmodule
`default_nettype wire

// ==== bench/raic_top_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
module raic_top_chk
(
	input wire logic	core_clk,
	input wire logic	rst,
	input wire logic	s_axi_bvalid,
	input wire logic	s_axi_bready,
	input wire logic	s_axi_arvalid,
	input wire logic	s_axi_arready,
	input wire logic	s_axi_rvalid,
	input wire logic	s_axi_rready,
	input wire logic [31:0]	s_axi_rdata,
	input wire logic	ctle_optimal,
	input wire logic	ctle_adapt_run,
	input wire logic	dfe_adapt_run,
	input wire logic	adapt_done,
	input wire logic	merit_use_horiz,
	input wire logic	merit_use_vert,
	input wire logic	merit_use_alt
);
	// ----------------
	// Clocking
	// ----------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	// DFE step start and end
	sequence dfe_start_s;
		!dfe_adapt_run ##1 dfe_adapt_run;
	endsequence
	sequence dfe_end_s;
		dfe_adapt_run ##1 !dfe_adapt_run;
	endsequence

	// Bus answers stand until taken, and a read answers the cycle after its address is taken
	bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer changed");
	read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	// Merit selection
	merit_alt_a: assert property (merit_use_alt |-> !merit_use_horiz && !merit_use_vert)
		else $error("alternate merit mixed");
	merit_any_a: assert property (!merit_use_alt |-> merit_use_horiz || merit_use_vert)
		else $error("no merit selected");
	// Adaptation order
	run_excl_a: assert property (!(ctle_adapt_run && dfe_adapt_run))
		else $error("both engines run");
	dfe_ctle_a: assert property (dfe_end_s |-> ctle_adapt_run)
		else $error("no CTLE after DFE");
	ctle_dfe_a: assert property (dfe_start_s |-> $past(ctle_adapt_run))
		else $error("DFE without CTLE");
	done_opt_a: assert property ($rose(adapt_done) |-> $past(ctle_optimal) && $past(ctle_adapt_run))
		else $error("done too early");
endmodule

bind raic_top raic_top_chk chk
(
	.core_clk(core_clk), .rst(rst), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .ctle_optimal(ctle_optimal),
	.ctle_adapt_run(ctle_adapt_run), .dfe_adapt_run(dfe_adapt_run), .adapt_done(adapt_done),
	.merit_use_horiz(merit_use_horiz), .merit_use_vert(merit_use_vert), .merit_use_alt(merit_use_alt)
);
`default_nettype wire

// ==== bench/retimer_adapt_irq_config_test.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "raic_defines.svh"
`define CHECK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
	$display("wrong value %s exp %h seen %h", n, e, g); end end
module retimer_adapt_irq_config_test;
	typedef struct {string n; logic [1:0] s; logic [33:0] v;} raic_note_t;
	logic		core_clk = 1'b0;
	logic		rst = 1'b1;
	logic [11:0]	awaddr = '0, araddr = '0;
	logic [31:0]	wdata = '0, rdata, rnd = 32'h9e8b;
	logic		awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, probe = 0;
	logic		perr = 0, lock = 1, sdet = 1, eyev = 0, copt = 0, ddone = 0;
	logic [7:0]	heye = '0, veye = '0;
	logic [1:0]	psel = '0, bresp, rresp;
	logic		awready, wready, bvalid, arready, rvalid, crun, drun, done, mh, mv, malt, irq;
	logic [7:0]	ri [8] = '{8'h01, 8'h1e, 8'h31, 8'h32, 8'h33, 8'h6e, 8'h40, 8'h41};
	logic [7:0]	rv [8] = '{8'h00, `RAIC_RST_EQ_CTRL, `RAIC_RST_ADAPT, `RAIC_RST_EYE_IRQ,
				`RAIC_RST_EYE_GATE, `RAIC_RST_ALT_MERIT, 8'h00, 8'h00};
	int		bad_count = 0, cmp_count = 0, cycles = 0;
	raic_note_t	q [$];
	raic_note_t	t;

	raic_top DUT
	(
		.core_clk(core_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pattern_error(perr),
		.cdr_lock_async(lock), .signal_detect_async(sdet), .eye_valid(eyev),
		.horizontal_eye_opening(heye), .vertical_eye_opening(veye), .ctle_optimal(copt),
		.dfe_done(ddone), .ctle_adapt_run(crun), .dfe_adapt_run(drun), .adapt_done(done),
		.merit_use_horiz(mh), .merit_use_vert(mv), .merit_use_alt(malt), .irq(irq)
	);

	// Clock
	always #2.5 core_clk = ~core_clk;

	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction

	// ----------------
	// Bus and probe drivers
	// ----------------
	task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] r);
		q.push_back('{"bresp", 2'h0, {r, 32'h0}});
		@(posedge core_clk);
		awaddr <= {2'b00, i, 2'b00};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do
		begin
			@(posedge core_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			bready <= bvalid && !bready;
		end
		while (!(bvalid && bready));
	endtask

	task automatic rd(input string n, input logic [7:0] i, input logic [1:0] r, input logic [31:0] d);
		q.push_back('{n, 2'h0, {r, d}});
		@(posedge core_clk);
		araddr <= {2'b00, i, 2'b00};
		arvalid <= 1'b1;
		do
		begin
			@(posedge core_clk);
			if (arready) arvalid <= 1'b0;
			rready <= rvalid && !rready;
		end
		while (!(rvalid && rready));
	endtask

	task automatic pins(input string n, input logic [1:0] s, input logic [2:0] v);
		q.push_back('{n, s, {31'h0, v}});
		@(posedge core_clk);
		psel <= s;
		probe <= 1'b1;
		@(posedge core_clk);
		probe <= 1'b0;
	endtask

	task pat();
		perr <= 1'b1;
		@(posedge core_clk);
		perr <= 1'b0;
	endtask

	task automatic eyet(input logic [7:0] lv, input logic [7:0] h, input logic [7:0] v);
		logic e;
		e = (h < {lv[7:4], 3'h0}) || (v < {lv[3:0], 3'h0});
		wr(8'h32, lv, 2'h0);
		heye <= h;
		veye <= v;
		eyev <= 1'b1;
		@(posedge core_clk);
		eyev <= 1'b0;
		rd("eye flag", 8'h40, 2'h0, {28'h0, e, 3'h0});
		wr(8'h40, 8'h08, 2'h0);
	endtask

	task fin(input string n);
		$display("test %s done", n);
	endtask

	task complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Result monitor against oldest note
	always @(posedge core_clk)
	begin
		if ((bvalid && bready) || (rvalid && rready) || probe)
		begin
			t = q.pop_front();
			case (t.s)
				2'h0: `CHECK(t.n, t.v, (bvalid && bready) ? {bresp, 32'h0} : {rresp, rdata})
				2'h1: `CHECK(t.n, t.v, {31'h0, malt, mv, mh})
				2'h2: `CHECK(t.n, t.v, {31'h0, done, drun, crun})
				default: `CHECK(t.n, t.v, {33'h0, irq})
			endcase
		end
	end

	// Hang guard
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			bad_count++;
			complete_run();
		end
	end

	// ----------------
	// Scenarios
	// ----------------
	initial
	begin
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		repeat (2) @(posedge core_clk);
		pins("mode01 run", 2'h2, 3'h1);
		for (int k = 0; k < 8; k++)
			rd("reset value", ri[k], 2'h0, {24'h0, rv[k]});
		rd("unmapped", 8'hff, `RAIC_RESP_SLVERR, 32'h0);
		wr(8'hff, 8'h00, `RAIC_RESP_SLVERR);
		copt <= 1'b1;
		pins("mode01 done", 2'h2, 3'h4);
		copt <= 1'b0;
		fin("reset");
		wr(8'h31, 8'hff, 2'h0);
		rd("adapt bits", 8'h31, 2'h0, 32'hfb);
		for (int m = 0; m < 4; m++)
		begin
			wr(8'h31, 8'(m << 3), 2'h0);
			pins("merit", 2'h1, (m == 1) ? 3'h1 : (m == 2) ? 3'h2 : 3'h3);
		end
		pins("mode00 run", 2'h2, 3'h0);
		wr(8'h6e, 8'hff, 2'h0);
		rd("alt bits", 8'h6e, 2'h0, 32'h80);
		pins("alt merit", 2'h1, 3'h4);
		wr(8'h6e, 8'h00, 2'h0);
		fin("merit");
		wr(8'h31, 8'h40, 2'h0);
		pins("no dfe", 2'h2, 3'h0);
		wr(8'h1e, 8'hf7, 2'h0);
		rd("eq bits", 8'h1e, 2'h0, 32'h02);
		wr(8'h31, 8'h40, 2'h0);
		pins("ctle first", 2'h2, 3'h1);
		copt <= 1'b1;
		pins("dfe", 2'h2, 3'h2);
		copt <= 1'b0;
		ddone <= 1'b1;
		pins("ctle again", 2'h2, 3'h1);
		ddone <= 1'b0;
		copt <= 1'b1;
		pins("mode10 done", 2'h2, 3'h4);
		copt <= 1'b0;
		wr(8'h33, 8'h23, 2'h0);
		heye <= 8'd15;
		veye <= 8'd24;
		wr(8'h31, 8'h60, 2'h0);
		repeat (2) @(posedge core_clk);
		pins("gate held", 2'h2, 3'h1);
		heye <= 8'd16;
		pins("gate open", 2'h2, 3'h2);
		ddone <= 1'b1;
		pins("ctle last", 2'h2, 3'h1);
		ddone <= 1'b0;
		copt <= 1'b1;
		pins("mode11 done", 2'h2, 3'h4);
		copt <= 1'b0;
		fin("sequence");
		wr(8'h41, 8'h0f, 2'h0);
		wr(8'h31, 8'h83, 2'h0);
		pat();
		pins("pattern irq", 2'h3, 3'h1);
		rd("pattern flag", 8'h40, 2'h0, 32'h1);
		wr(8'h40, 8'h01, 2'h0);
		pins("irq cleared", 2'h3, 3'h0);
		lock <= 1'b0;
		repeat (6) @(posedge core_clk);
		rd("lock status", 8'h01, 2'h0, 32'h20);
		sdet <= 1'b0;
		repeat (6) @(posedge core_clk);
		rd("carrier status", 8'h01, 2'h0, 32'h21);
		rd("irq flags", 8'h40, 2'h0, 32'h6);
		wr(8'h40, 8'h0f, 2'h0);
		wr(8'h31, 8'h00, 2'h0);
		lock <= 1'b1;
		sdet <= 1'b1;
		repeat (6) @(posedge core_clk);
		lock <= 1'b0;
		sdet <= 1'b0;
		pat();
		repeat (6) @(posedge core_clk);
		rd("disabled", 8'h40, 2'h0, 32'h0);
		lock <= 1'b1;
		sdet <= 1'b1;
		wr(8'h41, 8'h00, 2'h0);
		wr(8'h31, 8'h80, 2'h0);
		pat();
		pins("masked irq", 2'h3, 3'h0);
		wr(8'h41, 8'h01, 2'h0);
		pins("unmasked irq", 2'h3, 3'h1);
		wr(8'h40, 8'h01, 2'h0);
		eyet(8'h23, 8'd16, 8'd24);
		eyet(8'h23, 8'd16, 8'd23);
		for (int k = 0; k < 8; k++)
		begin
			rnd = xs(rnd);
			eyet(rnd[7:0], {1'b0, rnd[14:8]}, {1'b0, rnd[22:16]});
		end
		fin("interrupts");
		complete_run();
	end
endmodule
`default_nettype wire
